// ### src/drfc_core.sv
// refresh timer, dram refresh sequencer and its avalon-mm register slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`include "drfc_defines.svh"
`default_nettype none

// Operation
// - with refresh enabled, timer compare matches drive dram refresh cycles
// - refresh disabled at reset; no refresh then, counter works as interval timer
// - wait field 00..11 gives one to four wait states in cbr refresh
// - compare flag sets when counter equals constant
// - flag clears only after being read as one then written zero
// - interrupt enable bit gates the compare match interrupt, off at reset
// - clock select 000 stops counter, others pick clock divided 2..4096
// - registers read at any width, written only by 16-bit accesses
// - counter is an 8-bit read/write register counting prescaled clock
// - constant is an 8-bit read/write register, resets to all ones
module drfc_core (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // avalon-mm slave
   input  wire drfc_pkg::drfc_avl_req_t avlReq,
   output var  drfc_pkg::drfc_avl_rsp_t avlRsp,
   // interrupt, level, active high
   output logic                         irq,
   // dram refresh strobes
   output var  drfc_pkg::drfc_dram_t    dram
);

   drfc_pkg::drfc_state_t st;
   drfc_pkg::drfc_state_t next_st;

   // reset images of the two control registers, held whole so fields can be picked out;
   // a bit-select straight on a sized literal is not legal, hence the named constants
   localparam logic [15:0] CTRL_RST = `DRFC_CTRL_RESET;
   localparam logic [15:0] TCS_RST  = `DRFC_TCS_RESET;

   // how the core hangs together
   //
   // bus side:
   //   every request costs exactly one wait cycle. the first edge that sees read or
   //   write with waitrequest high latches the answer; the next edge is the one where
   //   the master sees waitrequest low, and only there does a write land. read data
   //   is captured one edge early so it stands, registered, in the answer cycle.
   //   outside the answer cycle read data is forced to zero, which keeps stale
   //   register contents off the bus and makes a misplaced sample easy to spot.
   //
   // write width:
   //   only the low halfword lane pattern is accepted for writes. any other byte
   //   enable still gets an answer, so a careless master never hangs, but nothing
   //   is stored. reads ignore byte enables and always return the whole word.
   //
   // timer:
   //   the prescaler runs free from reset and is never cleared by a select change.
   //   the trade-off is a first period after a select change that may be short by
   //   up to one divided clock; in exchange there is no extra clear path and the
   //   enable pulse is a plain mask compare. select code zero produces no pulse.
   //
   // compare:
   //   the compare is looked at only on an enable pulse, so a counter written equal
   //   to the constant does not match until the next pulse. a match clears the count
   //   on that same pulse, so the match period is constant plus one pulses.
   //   a software write to the counter wins over a pulse in the same cycle.
   //
   // flag clear:
   //   reading the control/status register while the flag is set arms the clear;
   //   the next write to that register disarms it, and clears the flag only if
   //   the written flag bit is zero. a match in the clearing cycle keeps the flag.
   //
   // refresh sequencer:
   //   one pending bit queues a single match while a refresh is running; further
   //   matches in that time are folded into it. clearing the enable drops it.
   //   column strobe leads row strobe by one cycle in both kinds of refresh. a cbr
   //   refresh holds the row strobe low for the wait setting plus one cycles, then
   //   both strobes rise together and one precharge cycle follows. self-refresh
   //   holds both strobes low until software clears the enable or the mode bit.
   //   the busy level covers the strobe cycles and the precharge cycle.
   //
   // interrupts:
   //   the compare flag, gated by its enable, and the masked sticky status share
   //   one registered level. sticky status bits set by hardware win over a
   //   write-one clear landing in the same cycle, so no event is ever lost.
   //
   // limitation:
   //   the register decode compares the full index, so aliases of the registers
   //   read as zero and swallow writes, like any unmapped index.

   // prescaler mask for a select code; zero code never ticks
   function automatic logic [11:0] divMask(input logic [2:0] sel);
      case (sel)
         3'h1:    divMask = `DRFC_DIV2_MASK;
         3'h2:    divMask = `DRFC_DIV8_MASK;
         3'h3:    divMask = `DRFC_DIV32_MASK;
         3'h4:    divMask = `DRFC_DIV128_MASK;
         3'h5:    divMask = `DRFC_DIV512_MASK;
         3'h6:    divMask = `DRFC_DIV2048_MASK;
         3'h7:    divMask = `DRFC_DIV4096_MASK;
         default: divMask = 12'h000;
      endcase
   endfunction : divMask

   // register readback; reserved bits are zero
   function automatic logic [31:0] readReg(input drfc_pkg::drfc_state_t s,
                                           input logic [27:0]           idx);
      readReg = 32'h0000_0000;
      case (idx)
         `DRFC_IDX_CTRL: begin
            readReg[`DRFC_CTRL_EN_BIT]                    = s.refEn;
            readReg[`DRFC_CTRL_MODE_BIT]                  = s.refMode;
            readReg[`DRFC_CTRL_WAIT_HI:`DRFC_CTRL_WAIT_LO] = s.waitSel;
         end
         `DRFC_IDX_TCS: begin
            readReg[`DRFC_TCS_CMF_BIT]                 = s.compare_match_flag;
            readReg[`DRFC_TCS_COMPARE_MATCH_IRQ_ENABLE_BIT]                = s.compare_match_irq_enable;
            readReg[`DRFC_TCS_CKS_HI:`DRFC_TCS_CKS_LO] = s.clkSel;
         end
         `DRFC_IDX_CNT:      readReg[7:0] = s.cnt;
         `DRFC_IDX_CONST:    readReg[7:0] = s.cons;
         `DRFC_IDX_IRQ_STAT: readReg[1:0] = s.irqStat;
         `DRFC_IDX_IRQ_MASK: readReg[1:0] = s.irqMask;
         default:            readReg = 32'h0000_0000;
      endcase
   endfunction : readReg

   // next-state logic for the whole core
   always_comb begin
      logic [27:0] idx;
      logic        wrTake;
      logic        rdTake;
      logic        tick;
      logic        match;
      logic        cmfClr;
      logic        evDone;
      logic [15:0] wd;
      idx     = avlReq.address[29:2];
      wd      = avlReq.writedata[15:0];
      next_st = st;
      // transfer completes at the edge where waitrequest is low
      wrTake  = avlReq.write && !st.rsp.waitrequest
                && (avlReq.byteenable == `DRFC_BE_HALF);
      rdTake  = avlReq.read && !st.rsp.waitrequest;
      evDone  = 1'b0;

      // bus handshake: one wait cycle, then a single ready cycle
      if ((avlReq.read || avlReq.write) && st.rsp.waitrequest) begin
         next_st.rsp.waitrequest = 1'b0;
         next_st.rsp.readdata    = avlReq.read ? readReg(st, idx) : 32'h0000_0000;
      end else begin
         next_st.rsp.waitrequest = 1'b1;
         next_st.rsp.readdata    = 32'h0000_0000;
      end

      // free-running prescaler, enable pulse on wrap of the selected bits
      next_st.presc = st.presc + 12'h001;
      tick = (st.clkSel != 3'h0)
             && ((st.presc & divMask(st.clkSel)) == divMask(st.clkSel));

      // counter and compare; match clears the count
      match = 1'b0;
      if (tick) begin
         if (st.cnt == st.cons) begin
            match       = 1'b1;
            next_st.cnt = 8'h00;
         end else begin
            next_st.cnt = st.cnt + 8'h01;
         end
      end

      // arm the flag clear when software sees it set
      if (rdTake && idx == `DRFC_IDX_TCS && st.compare_match_flag) begin
         next_st.cmfArmed = 1'b1;
      end

      // register writes; reserved bits never stored
      cmfClr = 1'b0;
      if (wrTake) begin
         case (idx)
            `DRFC_IDX_CTRL: begin
               next_st.refEn   = wd[`DRFC_CTRL_EN_BIT];
               next_st.refMode = wd[`DRFC_CTRL_MODE_BIT];
               next_st.waitSel = wd[`DRFC_CTRL_WAIT_HI:`DRFC_CTRL_WAIT_LO];
            end
            `DRFC_IDX_TCS: begin
               next_st.compare_match_irq_enable   = wd[`DRFC_TCS_COMPARE_MATCH_IRQ_ENABLE_BIT];
               next_st.clkSel = wd[`DRFC_TCS_CKS_HI:`DRFC_TCS_CKS_LO];
               // writing one to the flag does nothing
               cmfClr = st.cmfArmed && !wd[`DRFC_TCS_CMF_BIT];
               next_st.cmfArmed = 1'b0;
            end
            `DRFC_IDX_CNT: begin
               next_st.cnt = wd[7:0];
            end
            `DRFC_IDX_CONST: begin
               next_st.cons = wd[7:0];
            end
            `DRFC_IDX_IRQ_STAT: begin
               next_st.irqStat = st.irqStat & ~wd[1:0];
            end
            `DRFC_IDX_IRQ_MASK: begin
               next_st.irqMask = wd[1:0];
            end
            default: begin
               next_st.irqMask = st.irqMask;
            end
         endcase
      end

      // compare flag: a match in the clearing cycle wins
      if (match) begin
         next_st.compare_match_flag = 1'b1;
      end else if (cmfClr) begin
         next_st.compare_match_flag = 1'b0;
      end

      // a match requests one refresh only while refresh is enabled
      if (match && st.refEn) begin
         next_st.refPend = 1'b1;
      end
      if (!st.refEn) begin
         next_st.refPend = 1'b0;
      end

      // refresh sequencer
      case (st.fsm)
         drfc_pkg::DRFC_IDLE: begin
            next_st.dram.rasN = 1'b1;
            next_st.dram.casN = 1'b1;
            next_st.dram.busy = 1'b0;
            if (st.refPend && st.refEn) begin
               next_st.refPend   = match;
               next_st.fsm       = drfc_pkg::DRFC_CAS;
               next_st.dram.casN = 1'b0;
               next_st.dram.busy = 1'b1;
            end
         end
         drfc_pkg::DRFC_CAS: begin
            // cas leads ras in both refresh kinds
            next_st.dram.rasN = 1'b0;
            if (st.refMode) begin
               next_st.fsm = drfc_pkg::DRFC_SELF;
            end else begin
               next_st.fsm     = drfc_pkg::DRFC_RAS;
               next_st.waitCnt = {1'b0, st.waitSel};
            end
         end
         drfc_pkg::DRFC_RAS: begin
            // ras stays low for one cycle per wait state
            if (st.waitCnt == 3'h0) begin
               next_st.fsm       = drfc_pkg::DRFC_PRECHG;
               next_st.dram.rasN = 1'b1;
               next_st.dram.casN = 1'b1;
               evDone            = 1'b1;
            end else begin
               next_st.waitCnt = st.waitCnt - 3'h1;
            end
         end
         drfc_pkg::DRFC_SELF: begin
            // held until software leaves self-refresh
            if (!st.refEn || !st.refMode) begin
               next_st.fsm       = drfc_pkg::DRFC_PRECHG;
               next_st.dram.rasN = 1'b1;
               next_st.dram.casN = 1'b1;
               evDone            = 1'b1;
            end
         end
         drfc_pkg::DRFC_PRECHG: begin
            next_st.fsm       = drfc_pkg::DRFC_IDLE;
            next_st.dram.busy = 1'b0;
         end
         default: begin
            next_st.fsm       = drfc_pkg::DRFC_IDLE;
            next_st.dram.rasN = 1'b1;
            next_st.dram.casN = 1'b1;
            next_st.dram.busy = 1'b0;
         end
      endcase

      // sticky interrupt status; hardware set wins over a clear
      if (match) begin
         next_st.irqStat[`DRFC_IRQ_MATCH_BIT] = 1'b1;
      end
      if (evDone) begin
         next_st.irqStat[`DRFC_IRQ_DONE_BIT] = 1'b1;
      end

      // one level output from the flag gate and the masked status
      next_st.irq = (next_st.compare_match_flag && next_st.compare_match_irq_enable)
                    || ((next_st.irqStat & next_st.irqMask) != 2'h0);
   end

   // state register, synchronous reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st                  <= '0;
         st.refEn            <= CTRL_RST[`DRFC_CTRL_EN_BIT];
         st.refMode          <= CTRL_RST[`DRFC_CTRL_MODE_BIT];
         st.waitSel          <= CTRL_RST[`DRFC_CTRL_WAIT_HI:`DRFC_CTRL_WAIT_LO];
         st.compare_match_irq_enable             <= TCS_RST[`DRFC_TCS_COMPARE_MATCH_IRQ_ENABLE_BIT];
         st.clkSel           <= TCS_RST[`DRFC_TCS_CKS_HI:`DRFC_TCS_CKS_LO];
         st.cnt              <= `DRFC_CNT_RESET;
         st.cons             <= `DRFC_CONST_RESET;
         st.irqStat          <= `DRFC_IRQ_RESET;
         st.irqMask          <= `DRFC_IRQ_RESET;
         st.fsm              <= drfc_pkg::DRFC_IDLE;
         st.rsp.waitrequest  <= 1'b1;
         st.dram.rasN        <= 1'b1;
         st.dram.casN        <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign avlRsp = st.rsp;
   assign irq    = st.irq;
   assign dram   = st.dram;

endmodule : drfc_core
`default_nettype wire

// ### src/drfc_defines.svh
// register offsets, field positions, reset values and divider figures of the refresh block
`ifndef DRFC_DEFINES_SVH
`define DRFC_DEFINES_SVH

// register indices; byte address is four times the index
`define DRFC_IDX_CTRL      28'h5FFFFAC
`define DRFC_IDX_TCS       28'h5FFFFAE
`define DRFC_IDX_CNT       28'h5FFFFB0
`define DRFC_IDX_CONST     28'h5FFFFB2
`define DRFC_IDX_IRQ_STAT  28'h5FFFFB4
`define DRFC_IDX_IRQ_MASK  28'h5FFFFB6

// refresh_control fields
`define DRFC_CTRL_EN_BIT    7
`define DRFC_CTRL_MODE_BIT  6
`define DRFC_CTRL_WAIT_HI   5
`define DRFC_CTRL_WAIT_LO   4

// refresh_timer_control_status fields
`define DRFC_TCS_CMF_BIT    7
`define DRFC_TCS_COMPARE_MATCH_IRQ_ENABLE_BIT   6
`define DRFC_TCS_CKS_HI     5
`define DRFC_TCS_CKS_LO     3

// interrupt status / mask bits
`define DRFC_IRQ_MATCH_BIT  0
`define DRFC_IRQ_DONE_BIT   1

// reset values
`define DRFC_CTRL_RESET     16'h0000
`define DRFC_TCS_RESET      16'h0000
`define DRFC_CNT_RESET      8'h00
`define DRFC_CONST_RESET    8'hFF
`define DRFC_IRQ_RESET      2'h0

// the only write width the registers take: low halfword lanes
`define DRFC_BE_HALF        4'h3

// prescaler divide masks (divisor minus one) for select codes 1..7
`define DRFC_DIV2_MASK      12'h001
`define DRFC_DIV8_MASK      12'h007
`define DRFC_DIV32_MASK     12'h01F
`define DRFC_DIV128_MASK    12'h07F
`define DRFC_DIV512_MASK    12'h1FF
`define DRFC_DIV2048_MASK   12'h7FF
`define DRFC_DIV4096_MASK   12'hFFF

`endif

// ### src/drfc_pkg.sv
// types shared by the refresh control block and its bench
`default_nettype none
package drfc_pkg;

   // avalon-mm request from the master
   typedef struct packed {
      logic [29:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } drfc_avl_req_t;

   // avalon-mm answer to the master
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } drfc_avl_rsp_t;

   // dram strobes, active low, plus a busy level
   typedef struct packed {
      logic rasN;
      logic casN;
      logic busy;
   } drfc_dram_t;

   // refresh sequencer states
   typedef enum logic [4:0] {
      DRFC_IDLE    = 5'h01,
      DRFC_CAS     = 5'h02,
      DRFC_RAS     = 5'h04,
      DRFC_PRECHG  = 5'h08,
      DRFC_SELF    = 5'h10
   } drfc_fsm_t;

   // all state of the core
   typedef struct packed {
      logic          refEn;
      logic          refMode;
      logic [1:0]    waitSel;
      logic          compare_match_flag;
      logic          cmfArmed;
      logic          compare_match_irq_enable;
      logic [2:0]    clkSel;
      logic [7:0]    cnt;
      logic [7:0]    cons;
      logic [11:0]   presc;
      logic [1:0]    irqStat;
      logic [1:0]    irqMask;
      logic          refPend;
      drfc_fsm_t     fsm;
      logic [2:0]    waitCnt;
      drfc_avl_rsp_t rsp;
      logic          irq;
      drfc_dram_t    dram;
   } drfc_state_t;

endpackage : drfc_pkg
`default_nettype wire

// ### tb/drfc_monitor.sv
// port checker for the refresh control block
`include "drfc_defines.svh"
`default_nettype none
module drfc_monitor (
   // clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst,
   // bus and outputs
   input wire drfc_pkg::drfc_avl_req_t avlReq,
   input wire drfc_pkg::drfc_avl_rsp_t avlRsp,
   input wire logic                    irq,
   input wire drfc_pkg::drfc_dram_t    dram
);
   logic [3:0] ctrlShadow;
   logic [3:0] rasLow;
   logic [2:0] runCfg;
   logic       ctrlHit;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   assign ctrlHit = avlReq.address[29:2] == `DRFC_IDX_CTRL;
   // control bits mirrored at completion; config latched per refresh since writes may land mid-run
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrlShadow <= 4'h0;
         rasLow     <= 4'h0;
         runCfg     <= 3'h0;
      end else begin
         if (!avlRsp.waitrequest && avlReq.write && ctrlHit && avlReq.byteenable == 4'h3) begin
            ctrlShadow <= avlReq.writedata[7:4];
         end
         rasLow <= dram.rasN ? 4'h0 : rasLow + 4'h1;
         if (!dram.rasN && rasLow == 4'h0) begin
            runCfg <= ctrlShadow[2:0];
         end
      end
   end
   ack_latency_a: assert property ($rose(avlReq.read || avlReq.write) |=> !avlRsp.waitrequest)
      else $error("answer not one cycle after request");
   ack_pulse_a: assert property (!avlRsp.waitrequest |=> avlRsp.waitrequest)
      else $error("waitrequest low longer than one cycle");
   idle_data_a: assert property (avlRsp.waitrequest |-> avlRsp.readdata == 32'h0)
      else $error("read data outside an answer");
   ctrl_readback_a: assert property (!avlRsp.waitrequest && avlReq.read && ctrlHit
      |-> avlRsp.readdata == {24'h0, ctrlShadow, 4'h0}) else $error("control readback wrong");
   cas_lead_a: assert property ($fell(dram.rasN) |-> !dram.casN && !$past(dram.casN))
      else $error("row strobe not preceded by column strobe");
   cbr_length_a: assert property ($rose(dram.rasN) && !runCfg[2]
      |-> rasLow == {2'h0, runCfg[1:0]} + 4'h1) else $error("refresh wait count wrong");
   idle_off_a: assert property (!ctrlShadow[3] && dram.rasN && dram.casN
      |=> dram.rasN && dram.casN) else $error("refresh while disabled");
   self_hold_a: assert property (runCfg[2] && ctrlShadow[3] && ctrlShadow[2] && !dram.rasN
      |=> !dram.rasN) else $error("self refresh ended early");
   busy_ras_a: assert property (!dram.rasN |-> dram.busy)
      else $error("busy low during refresh");
endmodule : drfc_monitor
`default_nettype wire

// ### tb/drfc_dram_model.sv
// dram stand-in: counts refresh entries and flags a row strobe without column strobe
`default_nettype none
module drfc_dram_model (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst,
   // strobes from the block
   input wire drfc_pkg::drfc_dram_t dram,
   // observations
   output var int                   refreshes,
   output var logic                 orderBad
);
   logic prevRas;
   // a dram only sees refresh on a row strobe fall; column strobe must already be low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prevRas   <= 1'b1;
         refreshes <= 0;
         orderBad  <= 1'b0;
      end else begin
         prevRas <= dram.rasN;
         if (prevRas && !dram.rasN) begin
            refreshes <= refreshes + 1;
            if (dram.casN) begin
               orderBad <= 1'b1;
            end
         end
      end
   end
endmodule : drfc_dram_model
`default_nettype wire

// ### tb/tb_dram_refresh_control.sv
// self-checking bench for the refresh control block
`include "drfc_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); failures++; end end
module tb_dram_refresh_control;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [27:0] idx; logic [15:0] wd; logic [31:0] rd;} drfc_row_t;
   localparam logic [27:0] IX_CTRL = `DRFC_IDX_CTRL;
   localparam logic [27:0] IX_TCS = `DRFC_IDX_TCS;
   localparam logic [27:0] IX_CNT = `DRFC_IDX_CNT;
   localparam logic [27:0] IX_CONST = `DRFC_IDX_CONST;
   localparam logic [27:0] IX_STAT = `DRFC_IDX_IRQ_STAT;
   localparam logic [27:0] IX_MASK = `DRFC_IDX_IRQ_MASK;
   logic                    core_clk;
   logic                    rst;
   drfc_pkg::drfc_avl_req_t avlReq;
   drfc_pkg::drfc_avl_rsp_t avlRsp;
   logic                    irq;
   drfc_pkg::drfc_dram_t    dram;
   logic                    orderBad;
   logic [31:0]             rd;
   logic [31:0]             held;
   int                      failures, checked, refreshes, n, n0, lim;
   int                      divTab[8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};
   drfc_row_t               rows[8];
   // block under test and the dram behind it
   drfc_core DUT (.core_clk(core_clk), .rst(rst), .avlReq(avlReq), .avlRsp(avlRsp),
                  .irq(irq), .dram(dram));
   drfc_dram_model mem (.core_clk(core_clk), .rst(rst), .dram(dram),
                        .refreshes(refreshes), .orderBad(orderBad));
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   // one bus cycle held until waitrequest is seen low
   task automatic bus(input logic w, input logic [27:0] idx, input logic [15:0] d,
                      input logic [3:0] be);
      int k;
      k = 0;
      avlReq <= '{address: {idx, 2'b00}, read: !w, write: w, writedata: {16'h0, d},
                  byteenable: be};
      do begin
         @(posedge core_clk);
         k++;
      end while (avlRsp.waitrequest !== 1'b0 && k < 20);
      if (k >= 20) begin
         failures++;
         summarize();
      end
      rd = avlRsp.readdata;
      avlReq.read <= 1'b0;
      avlReq.write <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic wr(input logic [27:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d, 4'h3);
   endtask : wr
   task automatic rdExp(input string nm, input logic [27:0] idx, input logic [31:0] ex);
      bus(1'b0, idx, 16'h0, 4'hF);
      `CHK(nm, ex, rd)
   endtask : rdExp
   // edges from the previous row strobe fall to the next one
   task automatic waitFall(output int cyc);
      logic p;
      p = 1'b0;
      for (cyc = 1; cyc < 20000; cyc++) begin
         @(posedge core_clk);
         if (p && dram.rasN === 1'b0) break;
         p = dram.rasN;
      end
      if (cyc >= 20000) begin
         failures++;
         summarize();
      end
   endtask : waitFall
   // main sequence
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      avlReq = '0;
      failures = 0;
      checked = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdExp("ctrl reset", IX_CTRL, 32'h0);
      rdExp("tcs reset", IX_TCS, 32'h0);
      rdExp("cnt reset", IX_CNT, 32'h0);
      rdExp("const reset", IX_CONST, 32'hFF);
      rows = '{'{IX_CTRL, 16'hFFFF, 32'hF0}, '{IX_CTRL, 16'h0, 32'h0},
               '{IX_TCS, 16'h00FF, 32'h78}, '{IX_TCS, 16'h0, 32'h0},
               '{IX_CNT, 16'h1234, 32'h34}, '{IX_CONST, 16'hAB55, 32'h55},
               '{IX_MASK, 16'hFFFF, 32'h3}, '{28'h5FFFFA0, 16'hFFFF, 32'h0}};
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         rdExp("row", rows[i].idx, rows[i].rd);
      end
      bus(1'b1, IX_CTRL, 16'h0080, 4'h1);
      rdExp("narrow write", IX_CTRL, 32'h0);
      // every divider; third fall so leftovers of the previous setting are flushed
      for (int c = 1; c < 8; c++) begin
         lim = (c == 1) ? 8 : 2;
         wr(IX_TCS, 16'h0);
         wr(IX_CONST, 16'(lim - 1));
         wr(IX_CNT, 16'h0);
         wr(IX_CTRL, 16'(8'h80 | ((c % 4) << 4)));
         wr(IX_TCS, 16'(c << 3));
         repeat (3) waitFall(n);
         `CHK("period", lim * divTab[c], n)
      end
      wr(IX_TCS, 16'h0);
      bus(1'b0, IX_CNT, 16'h0, 4'hF);
      held = rd;
      repeat (300) @(posedge core_clk);
      rdExp("stopped cnt", IX_CNT, held);
      // compare flag, its clear sequence and interrupt gating with refresh off
      wr(IX_CTRL, 16'h0);
      wr(IX_MASK, 16'h0);
      wr(IX_CONST, 16'h3);
      wr(IX_CNT, 16'h0);
      n0 = refreshes;
      wr(IX_TCS, 16'h0050);
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge core_clk);
      `CHK("irq on", 1'b1, irq)
      rdExp("cnt cleared", IX_CNT, 32'h0);
      wr(IX_TCS, 16'h0050);
      rdExp("cmf kept", IX_TCS, 32'hD0);
      wr(IX_TCS, 16'h0010);
      rdExp("cmf cleared", IX_TCS, 32'h10);
      repeat (40) @(posedge core_clk);
      `CHK("irq gated", 1'b0, irq)
      rdExp("cmf set", IX_TCS, 32'h90);
      `CHK("no refresh", n0, refreshes)
      // self refresh, then the done event through status and mask
      wr(IX_TCS, 16'h0008);
      wr(IX_STAT, 16'h3);
      wr(IX_MASK, 16'h0);
      wr(IX_CTRL, 16'h00C0);
      waitFall(n);
      repeat (50) @(posedge core_clk);
      `CHK("self hold", 2'b00, {dram.rasN, dram.casN})
      wr(IX_TCS, 16'h0);
      wr(IX_CTRL, 16'h0);
      repeat (5) @(posedge core_clk);
      `CHK("self exit", 3'b110, dram)
      `CHK("irq masked", 1'b0, irq)
      rdExp("status", IX_STAT, 32'h3);
      wr(IX_MASK, 16'h2);
      @(posedge core_clk);
      `CHK("irq unmasked", 1'b1, irq)
      wr(IX_STAT, 16'h2);
      @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      // reset in mid-run
      wr(IX_CTRL, 16'h0030);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rdExp("ctrl rerst", IX_CTRL, 32'h0);
      `CHK("strobe order", 1'b0, orderBad)
      summarize();
   end
endmodule : tb_dram_refresh_control
bind drfc_core drfc_monitor u_mon (.core_clk(core_clk), .rst(rst), .avlReq(avlReq),
                                   .avlRsp(avlRsp), .irq(irq), .dram(dram));
`default_nettype wire
